// ### hdl/isw_write_path.sv
// internal write path: slave-loaded address and data words driving internal writes
// Contract
// R1: the write address is always word aligned, its two low bits fixed at zero.
// R2: both words are read-only from the register bus but read/write from the slave side.
// R3: slave bytes 0x00 to 0x03 hold the four bytes of the write address.
// R4: slave bytes 0x04 to 0x07 hold the write data, 0x07 being the most significant byte.
// R5: boot load places each fetched register address into the write address.
// R6: boot load places each fetched data word into the write data.
// R7: only the low 24 address bits drive internal accesses; the top byte has no effect.
// R8: with auto-increment on, writing byte 0x07 adds 4 to the write address.
// R9: with 4-byte size, writing byte 0x07 issues an internal write of the whole word.
// R10: the internal write takes its address from the write address register.
// R11: writes to bytes 0x04 to 0x06 only store the byte and start no access.
// R12: after a write of byte 0x07 the slave pointer wraps to 0x04.
// R13: after a read of byte 0x07 the slave pointer advances to 0x08.
// R14: otherwise the slave pointer moves up by one after every byte read or written.
`timescale 1ns/1ps
module isw_write_path
    import isw_pkg::*;
(
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic slv_ptr_load_in,
    input wire logic [7:0] slv_ptr_in,
    input wire logic slv_wr_in,
    input wire logic [7:0] slv_wdata_in,
    input wire logic slv_rd_in,
    output logic [7:0] slv_rdata_out,
    output logic [7:0] slv_ptr_out,
    input wire logic write_addr_autoinc_enable_in,
    input wire logic [1:0] write_access_size_in,
    input wire logic boot_addr_load_in,
    input wire logic [31:0] boot_addr_in,
    input wire logic boot_data_load_in,
    input wire logic [31:0] boot_data_in,
    input wire logic rb_rd_in,
    input wire logic rb_wr_in,
    input wire logic [RB_AW-1:0] rb_addr_in,
    output logic [31:0] rb_rdata_out,
    output logic rb_rvalid_out,
    output logic iw_req_out,
    output logic [INT_AW-1:0] iw_addr_out,
    output logic [31:0] iw_data_out,
    input wire logic iw_ack_in
);
    // ************************************************************
    // word registers
    // ************************************************************
    isw_word_if waddr_if ();
    isw_word_if wdata_if ();
    logic [7:0] ptr_reg;
    logic [31:0] addr_q;
    logic [31:0] data_q;
    logic in_addr;
    logic in_data;
    logic msb_wr;
    logic fire;
    logic inc_now;

    assign addr_q = waddr_if.q;
    assign data_q = wdata_if.q;
    assign in_addr = ptr_reg <= SLV_ADDR_HI; // see R3
    assign in_data = (ptr_reg >= SLV_DATA_LO) && (ptr_reg <= SLV_DATA_MSB); // see R4
    assign msb_wr = slv_wr_in && (ptr_reg == SLV_DATA_MSB);
    // only the msb byte starts an access; lower data bytes just store
    assign fire = msb_wr && (write_access_size_in == WRITE_ACCESS_SIZE_4BYTE); // see R9, see R11
    assign inc_now = msb_wr && write_addr_autoinc_enable_in; // see R8

    // rb_wr_in reaches no register: both words are read-only there
    assign waddr_if.word_load = boot_addr_load_in || inc_now; // see R5, see R8
    assign waddr_if.word_wdata = boot_addr_load_in ? boot_addr_in : addr_q + ADDR_STEP;
    assign waddr_if.byte_we = (slv_wr_in && in_addr) ? 4'(4'h1 << ptr_reg[1:0]) : 4'h0; // see R2
    assign waddr_if.byte_wdata = slv_wdata_in;
    assign wdata_if.word_load = boot_data_load_in; // see R6
    assign wdata_if.word_wdata = boot_data_in;
    assign wdata_if.byte_we = (slv_wr_in && in_data) ? 4'(4'h1 << ptr_reg[1:0]) : 4'h0; // see R4
    assign wdata_if.byte_wdata = slv_wdata_in;

    isw_word_reg #(
        .KEEP_MASK(ADDR_KEEP_MASK),
        .RESET_VALUE(RESET_WRITE_ADDRESS)
    ) u_addr (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .port_if(waddr_if)
    );

    isw_word_reg #(
        .KEEP_MASK(DATA_KEEP_MASK),
        .RESET_VALUE(RESET_WRITE_DATA)
    ) u_data (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .port_if(wdata_if)
    );

    // ************************************************************
    // slave byte pointer
    // ************************************************************
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            ptr_reg <= SLV_ADDR_LO;
        end else if (slv_ptr_load_in) begin
            ptr_reg <= slv_ptr_in;
        end else if (msb_wr) begin
            ptr_reg <= SLV_DATA_LO; // see R12
        end else if (slv_wr_in || slv_rd_in) begin
            ptr_reg <= 8'(ptr_reg + SLV_PTR_STEP); // see R13, see R14
        end
    end

    // ************************************************************
    // slave read data
    // ************************************************************
    // bytes outside this window belong to other logic and read as idle here
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            slv_rdata_out <= SLV_IDLE_BYTE;
            slv_ptr_out <= SLV_ADDR_LO;
        end else begin
            slv_ptr_out <= ptr_reg;
            if (in_addr) begin
                slv_rdata_out <= addr_q[ptr_reg[1:0]*8 +: 8]; // see R2, see R3
            end else if (in_data) begin
                slv_rdata_out <= data_q[ptr_reg[1:0]*8 +: 8]; // see R4
            end else begin
                slv_rdata_out <= SLV_IDLE_BYTE;
            end
        end
    end

    // ************************************************************
    // register bus read port
    // ************************************************************
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            rb_rdata_out <= 32'h00000000;
            rb_rvalid_out <= 1'b0;
        end else begin
            rb_rvalid_out <= rb_rd_in;
            if (rb_rd_in && rb_addr_in == OFS_WRITE_ADDRESS) begin
                rb_rdata_out <= addr_q; // see R2
            end else if (rb_rd_in && rb_addr_in == OFS_WRITE_DATA) begin
                rb_rdata_out <= data_q; // see R2
            end else begin
                rb_rdata_out <= 32'h00000000;
            end
        end
    end

    // ************************************************************
    // internal write request
    // ************************************************************
    // a new trigger wins over the ack of the previous one; a trigger while a
    // request is still pending replaces it, the master must pace itself
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            iw_req_out <= 1'b0;
            iw_addr_out <= 24'h000000;
            iw_data_out <= 32'h00000000;
        end else if (fire) begin
            iw_req_out <= 1'b1; // see R9
            iw_addr_out <= addr_q[INT_AW-1:0]; // see R7, see R10
            iw_data_out <= {slv_wdata_in, data_q[23:0]}; // see R9
        end else if (iw_ack_in) begin
            iw_req_out <= 1'b0;
        end
    end

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (srst_in);

    AST_ADDR_ALIGN: assert property (addr_q[1:0] == 2'h0) // see R1
        else $error("write address lost its alignment");
    AST_RB_READ_ADDR: assert property (rb_rd_in && rb_addr_in == OFS_WRITE_ADDRESS // see R2
        |=> rb_rvalid_out && rb_rdata_out == $past(addr_q))
        else $error("register bus read of address word wrong");
    AST_RB_READ_DATA: assert property (rb_rd_in && rb_addr_in == OFS_WRITE_DATA // see R2
        |=> rb_rvalid_out && rb_rdata_out == $past(data_q))
        else $error("register bus read of data word wrong");
    AST_RB_NO_WRITE: assert property (rb_wr_in && !slv_wr_in && !boot_addr_load_in // see R2
        && !boot_data_load_in |=> $stable(addr_q) && $stable(data_q))
        else $error("register bus write changed a word");
    AST_ADDR_BYTE1: assert property (slv_wr_in && !slv_ptr_load_in && ptr_reg == 8'h01 // see R3
        && !boot_addr_load_in |=> addr_q[15:8] == $past(slv_wdata_in))
        else $error("slave byte 0x01 not stored in address");
    // a pointer load beside the byte could aim the next write at 0x07, so it is left out
    AST_DATA_BYTE5: assert property (slv_wr_in && !slv_ptr_load_in && ptr_reg == 8'h05 // see R4
        && !boot_data_load_in
        |=> data_q[15:8] == $past(slv_wdata_in) ##1 (!iw_req_out || $past(iw_req_out, 2)))
        else $error("slave byte 0x05 not stored in data");
    AST_BOOT_ADDR: assert property (boot_addr_load_in // see R5
        |=> addr_q == ($past(boot_addr_in) & ADDR_KEEP_MASK))
        else $error("boot address not captured");
    AST_BOOT_DATA: assert property (boot_data_load_in |=> data_q == $past(boot_data_in)) // see R6
        else $error("boot data not captured");
    AST_AUTOINC: assert property (inc_now && !boot_addr_load_in // see R8
        |=> addr_q == $past(addr_q) + ADDR_STEP)
        else $error("auto-increment did not add four");
    AST_FIRE: assert property (fire |=> iw_req_out && iw_addr_out == $past(addr_q[23:0]) // see R10
        && iw_data_out[31:24] == $past(slv_wdata_in) && iw_data_out[23:0] == $past(data_q[23:0]))
        else $error("internal write word or address wrong");
    AST_NO_FIRE: assert property (!iw_req_out && !fire |=> !iw_req_out) // see R11
        else $error("internal write started without msb write");
    AST_NARROW_SIZE: assert property (msb_wr && write_access_size_in != WRITE_ACCESS_SIZE_4BYTE // see R9
        && !iw_req_out |=> !iw_req_out)
        else $error("internal write started with a narrow size");
    AST_WRAP: assert property (msb_wr && !slv_ptr_load_in |=> ptr_reg == SLV_DATA_LO) // see R12
        else $error("pointer did not wrap after msb write");
    AST_READ_ADV: assert property (slv_rd_in && !slv_wr_in && !slv_ptr_load_in // see R13
        && ptr_reg == SLV_DATA_MSB |=> ptr_reg == 8'h08)
        else $error("pointer did not advance after msb read");
    AST_STEP: assert property ((slv_wr_in || slv_rd_in) && !slv_ptr_load_in && !msb_wr // see R14
        |=> ptr_reg == 8'($past(ptr_reg) + SLV_PTR_STEP) ##1 slv_ptr_out == $past(ptr_reg))
        else $error("pointer did not step by one");

    COV_BLOCK_WRITE: cover property (fire ##[1:40] fire);
    COV_AUTOINC: cover property (inc_now && fire);
    COV_BOOT: cover property (boot_addr_load_in ##[1:10] boot_data_load_in);
    COV_MSB_READ: cover property (slv_rd_in && ptr_reg == SLV_DATA_MSB);
    COV_NARROW_SIZE: cover property (msb_wr && write_access_size_in != WRITE_ACCESS_SIZE_4BYTE);
endmodule : isw_write_path

// ### hdl/isw_pkg.sv
// constants shared by the internal write path of the slave bridge
package isw_pkg;
    // ************************************************************
    // register bus map
    // ************************************************************
    localparam int RB_AW = 17;
    localparam logic [16:0] OFS_WRITE_ADDRESS = 17'h1d200;
    localparam logic [16:0] OFS_WRITE_DATA = 17'h1d204;
    localparam logic [31:0] RESET_WRITE_ADDRESS = 32'h00000000;
    localparam logic [31:0] RESET_WRITE_DATA = 32'h00000000;
    localparam logic [31:0] ADDR_KEEP_MASK = 32'hfffffffc;
    localparam logic [31:0] DATA_KEEP_MASK = 32'hffffffff;
    localparam logic [31:0] ADDR_STEP = 32'h00000004;
    localparam int INT_AW = 24;
    // ************************************************************
    // slave peripheral byte addresses
    // ************************************************************
    localparam logic [7:0] SLV_ADDR_LO = 8'h00;
    localparam logic [7:0] SLV_ADDR_HI = 8'h03;
    localparam logic [7:0] SLV_DATA_LO = 8'h04;
    localparam logic [7:0] SLV_DATA_MSB = 8'h07;
    localparam logic [7:0] SLV_PTR_STEP = 8'h01;
    localparam logic [7:0] SLV_IDLE_BYTE = 8'h00;
    // ************************************************************
    // write access size encoding
    // ************************************************************
    localparam logic [1:0] WRITE_ACCESS_SIZE_4BYTE = 2'h2;
endpackage : isw_pkg

// ### hdl/isw_word_if.sv
// carrier between the bridge top and one byte-writable word register
`timescale 1ns/1ps
interface isw_word_if;
    logic [3:0] byte_we;
    logic [7:0] byte_wdata;
    logic word_load;
    logic [31:0] word_wdata;
    logic [31:0] q;
    modport ctl (output byte_we, output byte_wdata, output word_load, output word_wdata,
        input q);
    modport store (input byte_we, input byte_wdata, input word_load, input word_wdata,
        output q);
endinterface : isw_word_if

// ### hdl/isw_word_reg.sv
// 32-bit register with byte lanes, whole-word load and fixed-zero bit mask
`timescale 1ns/1ps
module isw_word_reg
    import isw_pkg::*;
#(
    parameter logic [31:0] KEEP_MASK = DATA_KEEP_MASK,
    parameter logic [31:0] RESET_VALUE = RESET_WRITE_DATA
) (
    input wire logic clk_in,
    input wire logic srst_in,
    isw_word_if.store port_if
);
    // ************************************************************
    // storage
    // ************************************************************
    // whole-word load wins over byte lanes so boot load is never torn
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            port_if.q <= RESET_VALUE & KEEP_MASK;
        end else if (port_if.word_load) begin
            port_if.q <= port_if.word_wdata & KEEP_MASK; // see R1
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (port_if.byte_we[i]) begin
                    port_if.q[i*8 +: 8] <= port_if.byte_wdata & KEEP_MASK[i*8 +: 8]; // see R1
                end
            end
        end
    end
endmodule : isw_word_reg

// ### tb/isw_master_model.sv
// model of the external slave-bus master driving the byte port
`timescale 1ns/1ps
module isw_master_model (
    input wire logic clk_in,
    output logic ptr_load_out,
    output logic [7:0] ptr_out,
    output logic wr_out,
    output logic [7:0] wdata_out,
    output logic rd_out
);
    // released lines show the inverse of their last value, never a stale copy
    initial begin
        ptr_load_out = 1'b0;
        ptr_out = 8'h00;
        wr_out = 1'b0;
        wdata_out = 8'h00;
        rd_out = 1'b0;
    end
    task put_ptr(input logic [7:0] p);
        @(posedge clk_in);
        ptr_load_out <= 1'b1;
        ptr_out <= p;
        @(posedge clk_in);
        ptr_load_out <= 1'b0;
        ptr_out <= ~p;
    endtask : put_ptr
    // whole word, lsb first, one byte every cycle
    task put_word(input logic [31:0] w);
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_in);
            wr_out <= 1'b1;
            wdata_out <= w[8*i+:8];
        end
        @(posedge clk_in);
        wr_out <= 1'b0;
        wdata_out <= ~w[31:24];
    endtask : put_word
    task put_byte(input logic [7:0] b);
        @(posedge clk_in);
        wr_out <= 1'b1;
        wdata_out <= b;
        @(posedge clk_in);
        wr_out <= 1'b0;
        wdata_out <= ~b;
    endtask : put_byte
    task get_byte();
        @(posedge clk_in);
        rd_out <= 1'b1;
        @(posedge clk_in);
        rd_out <= 1'b0;
    endtask : get_byte
endmodule : isw_master_model

// ### tb/isw_write_path_tb.sv
// self-checking bench for the internal write path
`timescale 1ns/1ps
module isw_write_path_tb;
    import isw_pkg::*;
    logic clk_in = 1'b0;
    logic srst_in = 1'b1;
    logic pl, wr, rd, ainc, rb_rd, rb_wr, rvalid, req, ack, bal, bdl;
    logic [7:0] pv, wd, rdat, ptr;
    logic [1:0] wsz;
    logic [16:0] rb_addr;
    logic [31:0] rdata, idata, ba, bd, d;
    logic [INT_AW-1:0] iaddr;
    int miscompares = 0;
    int checks_done = 0;
    always #4 clk_in = ~clk_in;
    isw_master_model mst (.clk_in(clk_in), .ptr_load_out(pl), .ptr_out(pv), .wr_out(wr),
        .wdata_out(wd), .rd_out(rd));
    isw_write_path uut (.clk_in(clk_in), .srst_in(srst_in), .slv_ptr_load_in(pl),
        .slv_ptr_in(pv), .slv_wr_in(wr), .slv_wdata_in(wd), .slv_rd_in(rd),
        .slv_rdata_out(rdat), .slv_ptr_out(ptr), .write_addr_autoinc_enable_in(ainc),
        .write_access_size_in(wsz), .boot_addr_load_in(bal), .boot_addr_in(ba),
        .boot_data_load_in(bdl), .boot_data_in(bd), .rb_rd_in(rb_rd), .rb_wr_in(rb_wr),
        .rb_addr_in(rb_addr), .rb_rdata_out(rdata), .rb_rvalid_out(rvalid),
        .iw_req_out(req), .iw_addr_out(iaddr), .iw_data_out(idata), .iw_ack_in(ack));
    task check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %0t got %h expected %h", $time, seen, exp);
        end
    endtask : check
    task stop_test();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : stop_test
    // read answer is looked at in the single cycle that rvalid stands
    task rb_read(input logic [16:0] a, output logic [31:0] v);
        @(posedge clk_in);
        rb_rd <= 1'b1;
        rb_addr <= a;
        @(posedge clk_in);
        rb_rd <= 1'b0;
        #1;
        check(32'(rvalid), 32'h1);
        v = rdata;
    endtask : rb_read
    task settle(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask : settle
    task ack_req();
        @(posedge clk_in);
        ack <= 1'b1;
        @(posedge clk_in);
        ack <= 1'b0;
        #1;
        check(32'(req), 32'h0);
    endtask : ack_req
    initial begin
        rb_rd = 1'b0;
        rb_wr = 1'b0;
        ack = 1'b0;
        bal = 1'b0;
        bdl = 1'b0;
        ainc = 1'b0;
        wsz = 2'h0;
        rb_addr = 17'h00000;
        ba = 32'h00000000;
        bd = 32'h00000000;
        repeat (3) @(posedge clk_in);
        srst_in <= 1'b0;
        rb_read(OFS_WRITE_ADDRESS, d);
        check(d, RESET_WRITE_ADDRESS);
        rb_read(OFS_WRITE_DATA, d);
        check(d, RESET_WRITE_DATA);
        mst.put_ptr(SLV_ADDR_LO);
        mst.put_word(32'h12345677);
        // a register-bus write must be ignored
        @(posedge clk_in);
        rb_wr <= 1'b1;
        rb_addr <= OFS_WRITE_ADDRESS;
        @(posedge clk_in);
        rb_wr <= 1'b0;
        rb_read(OFS_WRITE_ADDRESS, d);
        check(d, 32'h12345674);
        ainc <= 1'b1;
        wsz <= WRITE_ACCESS_SIZE_4BYTE;
        mst.put_byte(8'hef);
        mst.put_byte(8'hcd);
        mst.put_byte(8'hab);
        settle(2);
        check(32'(req), 32'h0);
        check(32'(ptr), 32'h07);
        mst.put_byte(8'h89);
        #1;
        check(32'(req), 32'h1);
        check(idata, 32'h89abcdef);
        check(32'(iaddr), 32'h345674);
        settle(1);
        check(32'(ptr), 32'(SLV_DATA_LO));
        ack_req();
        rb_read(OFS_WRITE_ADDRESS, d);
        check(d, 32'h12345678);
        // next word goes straight on from the wrapped pointer
        ainc <= 1'b0;
        mst.put_word(32'hcafe0bad);
        #1;
        check(idata, 32'hcafe0bad);
        check(32'(iaddr), 32'h345678);
        ack_req();
        rb_read(OFS_WRITE_ADDRESS, d);
        check(d, 32'h12345678);
        mst.put_ptr(SLV_DATA_MSB);
        settle(2);
        check(32'(rdat), 32'hca);
        mst.get_byte();
        settle(2);
        check(32'(ptr), 32'h08);
        // a narrow size still stores and wraps but must not start an access
        @(posedge clk_in);
        wsz <= 2'h1;
        mst.put_ptr(SLV_DATA_MSB);
        mst.put_byte(8'h5a);
        settle(2);
        check(32'(req), 32'h0);
        check(32'(ptr), 32'(SLV_DATA_LO));
        rb_read(OFS_WRITE_DATA, d);
        check(d, 32'h5afe0bad);
        rb_read(17'h1d208, d);
        check(d, 32'h00000000);
        @(posedge clk_in);
        bal <= 1'b1;
        ba <= 32'hfedcba99;
        bdl <= 1'b1;
        bd <= 32'h01020304;
        @(posedge clk_in);
        bal <= 1'b0;
        bdl <= 1'b0;
        rb_read(OFS_WRITE_ADDRESS, d);
        check(d, 32'hfedcba98);
        rb_read(OFS_WRITE_DATA, d);
        check(d, 32'h01020304);
        // reset in mid-run returns the data word and the pointer to their reset values
        @(posedge clk_in);
        srst_in <= 1'b1;
        @(posedge clk_in);
        srst_in <= 1'b0;
        rb_read(OFS_WRITE_DATA, d);
        check(d, RESET_WRITE_DATA);
        check(32'(ptr), 32'(SLV_ADDR_LO));
        stop_test();
    end
    // the sequence needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk_in);
        miscompares++;
        stop_test();
    end
endmodule : isw_write_path_tb
